// *** logic/ucc_consts.svh ***
// Overview of operation
// - Non-queue: holding empty when shifter loads
// - Tx empty interrupt gated by enable bit 1
// - Non-queue: bit 6 once shifter empty
// - Queue mode: holding empty means queue empty
// - Queue mode: bit 6 needs queue, shifter empty
// - Start checked at eighth tick, centre sampling
// - Parity, framing, break shown in status 2-4
// - Receive read pops, tags follow next byte
// - Data interrupt per character or trigger level
// - Time-out: four characters plus twelve bits
// - Receive interrupts gated by enable bit 0
// - Receive queue sixteen by eleven bits
// - Queue mode: receive register shows oldest
// - Modem control bit 4 selects loopback
// - Loopback feeds transmit shifter into receiver
// - Loopback: pin mark, requests off, inputs ignored
// - Address 0 is receive/transmit data
// - Divisor bytes at 0 and 1 when enabled, except line control BF
// - Address 2 status/control, 1 interrupt enables
// - Addresses 3-7: line, modem, status, scratch
// - Start, data LSB first, parity, stops, 16 ticks
`ifndef UCC_CONSTS_SVH
`define UCC_CONSTS_SVH
`define UCC_ADDR_DATA 3'h0
`define UCC_ADDR_IEN 3'h1
`define UCC_ADDR_ISTAT 3'h2
`define UCC_ADDR_LCTL 3'h3
`define UCC_ADDR_MCTL 3'h4
`define UCC_ADDR_LSTAT 3'h5
`define UCC_ADDR_MSTAT 3'h6
`define UCC_ADDR_SCRATCH 3'h7
`define UCC_LCTL_SPECIAL 8'hbf
`define UCC_LCTL_DLAB 7
`define UCC_LCTL_BRK 6
`define UCC_LCTL_STICK 5
`define UCC_LCTL_EVEN 4
`define UCC_LCTL_PEN 3
`define UCC_LCTL_STOP 2
`define UCC_MCTL_LOOP 4
`define UCC_MCTL_RTS 1
`define UCC_MCTL_DTR 0
`define UCC_IEN_RX 0
`define UCC_IEN_TX 1
`define UCC_IEN_LS 2
`define UCC_IEN_MS 3
`define UCC_QCTL_EN 0
`define UCC_QCTL_RXRST 1
`define UCC_QCTL_TXRST 2
`define UCC_TAG_PE 8
`define UCC_TAG_FE 9
`define UCC_TAG_BRK 10
`define UCC_ID_LS 4'h6
`define UCC_ID_RX 4'h4
`define UCC_ID_TO 4'hc
`define UCC_ID_TX 4'h2
`define UCC_ID_MS 4'h0
`define UCC_ID_NONE 4'h1
`define UCC_DIVL_RST 8'h01
`define UCC_REG_RST 8'h00
`define UCC_QDEPTH 5'h10
`define UCC_SKID 2'h2
`define UCC_WL_BASE 4'h5
`define UCC_BIT_TICKS 16
`define UCC_TICK_LAST 4'hf
`define UCC_START_LAST 4'h7
`define UCC_TOUT_CHARS 4
`define UCC_TOUT_BITS 12
`define UCC_TRIG0 5'h01
`define UCC_TRIG1 5'h04
`define UCC_TRIG2 5'h08
`define UCC_TRIG3 5'h0e
`endif

// *** logic/ucc_pkg.sv ***
package ucc_pkg;
    typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1, TX_DATA = 2'h3} ucc_tx_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2
    } ucc_rx_t;
    typedef enum logic [3:0] {
        SEL_DATA, SEL_DIVL, SEL_DIVH, SEL_IEN, SEL_ISTAT, SEL_LCTL,
        SEL_MCTL, SEL_LSTAT, SEL_MSTAT, SEL_SCRATCH, SEL_NONE
    } ucc_sel_t;
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ucc_bus_t;
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ucc_modem_t;
    typedef struct packed {
        logic [7:0] lctl, ien, mctl, divl, divh, scratch, rdata;
        logic fifo_en;
        logic [1:0] trig;
        logic [15:0] div_cnt;
        logic tick;
        logic [15:0][7:0] txq;
        logic [4:0] tx_wp, tx_rp;
        ucc_tx_t tx_st;
        logic [10:0] tx_sh;
        logic [3:0] tx_left, tx_ph;
        logic txd, pin, thre_int;
        logic rx_s1, rx_s2, rx_prev;
        logic [3:0] ms_s1, ms_s2, ms_prev, ms_delta;
        ucc_rx_t rx_st;
        logic [3:0] rx_ph, rx_idx;
        logic [8:0] rx_sh;
        logic [1:0][10:0] sk;
        logic [1:0] sk_cnt;
        logic [15:0][10:0] rxq;
        logic [4:0] rx_wp, rx_rp;
        logic ovr, tout;
        logic [9:0] tout_cnt;
    } ucc_state_t;
endpackage

// *** logic/ucc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ucc_consts.svh"

module ucc_core import ucc_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire ucc_bus_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic rx_i,
    input wire ucc_modem_t modem_n_i,
    output logic tx_o,
    output logic rts_n_o,
    output logic dtr_n_o,
    output logic irq_o
);

    // ****************************************
    // helper functions
    // ****************************************

    // register select from address and line control
    function automatic ucc_sel_t ucc_decode(input logic [2:0] a, input logic [7:0] lctl);
        logic dlab;
        logic spec;
        dlab = lctl[`UCC_LCTL_DLAB];
        spec = (lctl == `UCC_LCTL_SPECIAL);
        if (a == `UCC_ADDR_DATA && dlab && !spec) begin
            ucc_decode = SEL_DIVL;
        end else if (a == `UCC_ADDR_IEN && dlab && !spec) begin
            ucc_decode = SEL_DIVH;
        end else if (dlab && (a == `UCC_ADDR_DATA || a == `UCC_ADDR_IEN)) begin
            ucc_decode = SEL_NONE;
        end else if (a == `UCC_ADDR_DATA) begin
            ucc_decode = SEL_DATA;
        end else if (a == `UCC_ADDR_IEN) begin
            ucc_decode = SEL_IEN;
        end else if (a == `UCC_ADDR_ISTAT) begin
            ucc_decode = SEL_ISTAT;
        end else if (a == `UCC_ADDR_LCTL) begin
            ucc_decode = SEL_LCTL;
        end else if (a == `UCC_ADDR_MCTL) begin
            ucc_decode = SEL_MCTL;
        end else if (a == `UCC_ADDR_LSTAT) begin
            ucc_decode = SEL_LSTAT;
        end else if (a == `UCC_ADDR_MSTAT) begin
            ucc_decode = SEL_MSTAT;
        end else begin
            ucc_decode = SEL_SCRATCH;
        end
    endfunction

    // data bits kept for word length
    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        wl_mask = 8'hff >> (3'h3 - {1'b0, wl});
    endfunction

    // parity bit that goes with a character
    function automatic logic par_of(input logic [7:0] d, input logic [7:0] lctl);
        if (lctl[`UCC_LCTL_STICK]) begin
            par_of = ~lctl[`UCC_LCTL_EVEN];
        end else begin
            par_of = (^(d & wl_mask(lctl[1:0]))) ^ ~lctl[`UCC_LCTL_EVEN];
        end
    endfunction

    // frame without start bit: data, parity, then ones for stops
    function automatic logic [10:0] tx_frame(input logic [7:0] d, input logic [7:0] lctl);
        logic [3:0] nbits;
        tx_frame = 11'h7ff;
        nbits = `UCC_WL_BASE + {2'h0, lctl[1:0]};
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nbits) begin
                tx_frame[i] = d[i];
            end
        end
        if (lctl[`UCC_LCTL_PEN]) begin
            tx_frame[nbits] = par_of(d, lctl);
        end
    endfunction

    // ****************************************
    // state and derived signals
    // ****************************************

    ucc_state_t s;
    ucc_state_t next_s;
    ucc_sel_t sel;
    logic wr_en, rd_en, loop, pen, rx_in;
    logic [4:0] cap, tx_cnt, rx_cnt, trig_lvl;
    logic [3:0] nb, nbits_m1, isr_id, mst;
    logic [10:0] head;
    logic [15:0] div_m1;
    logic [9:0] tout_lim;
    logic [7:0] lstat, istat, mstat;
    logic sk_in_ready, sk_out_valid, sk_out_ready;

    assign sel = ucc_decode(bus_i.addr, s.lctl);
    assign wr_en = bus_i.cs & bus_i.wr;
    assign rd_en = bus_i.cs & bus_i.rd;
    assign loop = s.mctl[`UCC_MCTL_LOOP];
    assign pen = s.lctl[`UCC_LCTL_PEN];
    assign rx_in = loop ? s.txd : s.rx_s2;
    assign cap = s.fifo_en ? `UCC_QDEPTH : 5'h01;
    assign tx_cnt = s.tx_wp - s.tx_rp;
    assign rx_cnt = s.rx_wp - s.rx_rp;
    // head entry is the oldest byte
    assign head = (rx_cnt != 5'h00) ? s.rxq[s.rx_rp[3:0]] : 11'h000;
    assign nb = `UCC_WL_BASE + {2'h0, s.lctl[1:0]};
    assign nbits_m1 = nb + {3'h0, pen} - 4'h1;
    assign div_m1 = ({s.divh, s.divl} == 16'h0000) ? 16'h0000 : {s.divh, s.divl} - 16'h0001;
    // four characters plus twelve bits, in ticks
    assign tout_lim = 10'((`UCC_TOUT_CHARS * 32'(nb) + `UCC_TOUT_BITS) * `UCC_BIT_TICKS - 1);
    assign mst = loop ? 4'h0 : ~s.ms_s2;
    assign mstat = {mst, s.ms_delta};

    // two-entry buffer handshake between receiver and queue
    assign sk_in_ready = s.sk_cnt < `UCC_SKID;
    assign sk_out_valid = s.sk_cnt != 2'h0;
    assign sk_out_ready = rx_cnt < cap;

    // trigger level decode
    always_comb begin
        case (s.trig)
            2'h0: trig_lvl = `UCC_TRIG0;
            2'h1: trig_lvl = `UCC_TRIG1;
            2'h2: trig_lvl = `UCC_TRIG2;
            default: trig_lvl = `UCC_TRIG3;
        endcase
    end

    // line status; tags come from the head entry
    always_comb begin
        lstat = 8'h00;
        lstat[0] = rx_cnt != 5'h00;
        lstat[1] = s.ovr;
        lstat[2] = head[`UCC_TAG_PE];
        lstat[3] = head[`UCC_TAG_FE];
        lstat[4] = head[`UCC_TAG_BRK];
        lstat[5] = tx_cnt == 5'h00;
        lstat[6] = (tx_cnt == 5'h00) && (s.tx_st == TX_IDLE);
    end

    // interrupt priority: line, data, time-out, transmit, modem
    always_comb begin
        if (s.ien[`UCC_IEN_LS] && (s.ovr || lstat[4:2] != 3'h0)) begin
            isr_id = `UCC_ID_LS;
        end else if (s.ien[`UCC_IEN_RX] && (s.fifo_en ? rx_cnt >= trig_lvl : rx_cnt != 5'h00)) begin
            isr_id = `UCC_ID_RX;
        end else if (s.ien[`UCC_IEN_RX] && s.tout) begin
            isr_id = `UCC_ID_TO;
        end else if (s.ien[`UCC_IEN_TX] && s.thre_int) begin
            isr_id = `UCC_ID_TX;
        end else if (s.ien[`UCC_IEN_MS] && s.ms_delta != 4'h0) begin
            isr_id = `UCC_ID_MS;
        end else begin
            isr_id = `UCC_ID_NONE;
        end
        istat = {s.fifo_en, s.fifo_en, 2'h0, isr_id};
    end

    // ****************************************
    // next state
    // ****************************************

    always_comb begin
        logic thre_set, tx_push, rx_pop, rx_push, rx_rst, tx_rst, c_v;
        logic [10:0] c_w;
        logic [1:0] skc;
        thre_set = 1'b0;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        rx_push = 1'b0;
        rx_rst = 1'b0;
        tx_rst = 1'b0;
        c_v = 1'b0;
        c_w = 11'h000;
        skc = s.sk_cnt;
        next_s = s;

        // pins pass two flops before use
        next_s.rx_s1 = rx_i;
        next_s.rx_s2 = s.rx_s1;
        next_s.ms_s1 = modem_n_i;
        next_s.ms_s2 = s.ms_s1;
        next_s.rx_prev = rx_in;

        // 16x tick from the divisor
        if (s.div_cnt >= div_m1) begin
            next_s.div_cnt = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + 16'h0001;
            next_s.tick = 1'b0;
        end

        // host writes
        if (wr_en && sel == SEL_DATA) begin
            next_s.thre_int = 1'b0;
            // full queue drops the byte
            if (tx_cnt < cap) begin
                next_s.txq[s.tx_wp[3:0]] = bus_i.wdata;
                next_s.tx_wp = s.tx_wp + 5'h01;
                tx_push = 1'b1;
            end
        end else if (wr_en && sel == SEL_DIVL) begin
            next_s.divl = bus_i.wdata;
        end else if (wr_en && sel == SEL_DIVH) begin
            next_s.divh = bus_i.wdata;
        end else if (wr_en && sel == SEL_IEN) begin
            next_s.ien = {4'h0, bus_i.wdata[3:0]};
            // enabling while already empty raises it at once
            thre_set = !s.ien[`UCC_IEN_TX] && bus_i.wdata[`UCC_IEN_TX] && tx_cnt == 5'h00;
        end else if (wr_en && sel == SEL_ISTAT) begin
            next_s.fifo_en = bus_i.wdata[`UCC_QCTL_EN];
            next_s.trig = bus_i.wdata[7:6];
            rx_rst = bus_i.wdata[`UCC_QCTL_RXRST];
            tx_rst = bus_i.wdata[`UCC_QCTL_TXRST];
        end else if (wr_en && sel == SEL_LCTL) begin
            next_s.lctl = bus_i.wdata;
        end else if (wr_en && sel == SEL_MCTL) begin
            next_s.mctl = {3'h0, bus_i.wdata[4:0]};
        end else if (wr_en && sel == SEL_SCRATCH) begin
            next_s.scratch = bus_i.wdata;
        end

        // host reads; clears come before hardware sets
        if (rd_en && sel == SEL_DATA) begin
            next_s.rdata = head[7:0];
            // pop so next byte and tags show
            if (rx_cnt != 5'h00) begin
                next_s.rx_rp = s.rx_rp + 5'h01;
                rx_pop = 1'b1;
            end
            next_s.tout = 1'b0;
        end else if (rd_en && sel == SEL_DIVL) begin
            next_s.rdata = s.divl;
        end else if (rd_en && sel == SEL_DIVH) begin
            next_s.rdata = s.divh;
        end else if (rd_en && sel == SEL_IEN) begin
            next_s.rdata = s.ien;
        end else if (rd_en && sel == SEL_ISTAT) begin
            next_s.rdata = istat;
            if (isr_id == `UCC_ID_TX) begin
                next_s.thre_int = 1'b0;
            end
        end else if (rd_en && sel == SEL_LCTL) begin
            next_s.rdata = s.lctl;
        end else if (rd_en && sel == SEL_MCTL) begin
            next_s.rdata = s.mctl;
        end else if (rd_en && sel == SEL_LSTAT) begin
            next_s.rdata = lstat;
            next_s.ovr = 1'b0;
        end else if (rd_en && sel == SEL_MSTAT) begin
            next_s.rdata = mstat;
            next_s.ms_delta = 4'h0;
        end else if (rd_en && sel == SEL_SCRATCH) begin
            next_s.rdata = s.scratch;
        end else if (rd_en) begin
            next_s.rdata = 8'h00;
        end

        // modem deltas; a change in the read cycle is kept
        next_s.ms_prev = mst;
        next_s.ms_delta = next_s.ms_delta | (mst ^ s.ms_prev);

        case (s.tx_st)
            TX_IDLE: begin
                if (s.tick && tx_cnt != 5'h00) begin
                    next_s.tx_sh = tx_frame(s.txq[s.tx_rp[3:0]], s.lctl);
                    next_s.tx_rp = s.tx_rp + 5'h01;
                    next_s.tx_left = nb + {3'h0, pen} + (s.lctl[`UCC_LCTL_STOP] ? 4'h2 : 4'h1);
                    next_s.tx_ph = 4'h0;
                    next_s.txd = 1'b0;
                    next_s.tx_st = TX_START;
                    thre_set = thre_set || (tx_cnt == 5'h01 && !tx_push);
                end
            end
            TX_START: begin
                if (s.tick && s.tx_ph == `UCC_TICK_LAST) begin
                    next_s.tx_ph = 4'h0;
                    next_s.txd = s.tx_sh[0];
                    next_s.tx_st = TX_DATA;
                end else if (s.tick) begin
                    next_s.tx_ph = s.tx_ph + 4'h1;
                end
            end
            TX_DATA: begin
                if (s.tick && s.tx_ph == `UCC_TICK_LAST) begin
                    next_s.tx_ph = 4'h0;
                    if (s.tx_left == 4'h1) begin
                        next_s.txd = 1'b1;
                        next_s.tx_st = TX_IDLE;
                    end else begin
                        next_s.tx_left = s.tx_left - 4'h1;
                        next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
                        next_s.txd = s.tx_sh[1];
                    end
                end else if (s.tick) begin
                    next_s.tx_ph = s.tx_ph + 4'h1;
                end
            end
            default: begin
                next_s.tx_st = TX_IDLE;
            end
        endcase

        case (s.rx_st)
            RX_IDLE: begin
                if (s.rx_prev && !rx_in) begin
                    next_s.rx_ph = 4'h0;
                    next_s.rx_st = RX_START;
                end
            end
            RX_START: begin
                if (s.tick && s.rx_ph == `UCC_START_LAST) begin
                    next_s.rx_ph = 4'h0;
                    next_s.rx_idx = 4'h0;
                    next_s.rx_sh = 9'h000;
                    // a high line here was a glitch
                    next_s.rx_st = rx_in ? RX_IDLE : RX_DATA;
                end else if (s.tick) begin
                    next_s.rx_ph = s.rx_ph + 4'h1;
                end
            end
            RX_DATA: begin
                if (s.tick && s.rx_ph == `UCC_TICK_LAST) begin
                    next_s.rx_ph = 4'h0;
                    next_s.rx_sh[s.rx_idx] = rx_in;
                    if (s.rx_idx == nbits_m1) begin
                        next_s.rx_st = RX_STOP;
                    end else begin
                        next_s.rx_idx = s.rx_idx + 4'h1;
                    end
                end else if (s.tick) begin
                    next_s.rx_ph = s.rx_ph + 4'h1;
                end
            end
            RX_STOP: begin
                if (s.tick && s.rx_ph == `UCC_TICK_LAST) begin
                    // tags built at the stop centre
                    c_v = 1'b1;
                    c_w[7:0] = s.rx_sh[7:0] & wl_mask(s.lctl[1:0]);
                    c_w[`UCC_TAG_PE] = pen && (s.rx_sh[nb] != par_of(s.rx_sh[7:0], s.lctl));
                    c_w[`UCC_TAG_FE] = !rx_in;
                    c_w[`UCC_TAG_BRK] = !rx_in && s.rx_sh == 9'h000;
                    next_s.rx_st = RX_IDLE;
                end else if (s.tick) begin
                    next_s.rx_ph = s.rx_ph + 4'h1;
                end
            end
            default: begin
                next_s.rx_st = RX_IDLE;
            end
        endcase

        // buffer drains into the eleven-bit queue
        if (sk_out_valid && sk_out_ready) begin
            next_s.rxq[s.rx_wp[3:0]] = s.sk[0];
            next_s.rx_wp = s.rx_wp + 5'h01;
            next_s.sk[0] = s.sk[1];
            skc = skc - 2'h1;
            rx_push = 1'b1;
        end
        // a full buffer loses the new character as overrun
        // room if not full now, or if a slot drained this cycle
        if (c_v && (sk_in_ready || rx_push)) begin
            next_s.sk[skc[0]] = c_w;
            skc = skc + 2'h1;
        end else if (c_v) begin
            next_s.ovr = 1'b1;
        end
        next_s.sk_cnt = skc;

        if (rx_push || rx_pop) begin
            next_s.tout_cnt = 10'h000;
        end else if (s.tick && rx_cnt != 5'h00 && !s.tout) begin
            if (s.tout_cnt >= tout_lim) begin
                next_s.tout = 1'b1;
            end else begin
                next_s.tout_cnt = s.tout_cnt + 10'h001;
            end
        end

        // queue resets; the buffer is flushed with the receive side
        if (rx_rst) begin
            next_s.rx_rp = next_s.rx_wp;
            next_s.sk_cnt = 2'h0;
            next_s.tout = 1'b0;
        end
        if (tx_rst) begin
            next_s.tx_rp = next_s.tx_wp;
        end
        if (thre_set) begin
            next_s.thre_int = 1'b1;
        end

        // pin held at mark in loopback
        next_s.pin = loop ? 1'b1 : (s.lctl[`UCC_LCTL_BRK] ? 1'b0 : s.txd);
    end

    // ****************************************
    // state register
    // ****************************************

    // reset loads constants only; lines idle at mark
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s <= '0;
            s.divl <= `UCC_DIVL_RST;
            s.txd <= 1'b1;
            s.pin <= 1'b1;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rx_prev <= 1'b1;
            s.ms_s1 <= 4'hf;
            s.ms_s2 <= 4'hf;
        end else begin
            s <= next_s;
        end
    end

    // outputs; requests go inactive in loopback
    assign rdata_o = s.rdata;
    assign tx_o = s.pin;
    assign rts_n_o = ~(s.mctl[`UCC_MCTL_RTS] & ~loop);
    assign dtr_n_o = ~(s.mctl[`UCC_MCTL_DTR] & ~loop);
    assign irq_o = ~isr_id[0];

endmodule

`default_nettype wire

// *** bench/ucc_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucc_core_asserts import ucc_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire ucc_bus_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic rx_i,
    input wire ucc_modem_t modem_n_i,
    input wire logic tx_o,
    input wire logic rts_n_o,
    input wire logic dtr_n_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic dlab;
    logic [7:0] ien, mctl, scratch;
    wire logic wr = bus_i.cs && bus_i.wr;
    wire logic rd = bus_i.cs && bus_i.rd;
    // shadow of host settings; interrupt enables only reachable with divisor access off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {dlab, ien, mctl, scratch} <= '0;
        end else if (wr) begin
            if (bus_i.addr == 3'h3) dlab <= bus_i.wdata[7];
            if (bus_i.addr == 3'h1 && !dlab) ien <= {4'h0, bus_i.wdata[3:0]};
            if (bus_i.addr == 3'h4) mctl <= {3'h0, bus_i.wdata[4:0]};
            if (bus_i.addr == 3'h7) scratch <= bus_i.wdata;
        end
    end
    // ********
    // checks
    // ********
    a_loop_pin_mark: assert property (mctl[4] && $past(mctl[4]) && $past(mctl[4], 2) |-> tx_o)
        else $error("serial pin left mark in loopback");
    a_loop_req_off: assert property (mctl[4] |-> rts_n_o && dtr_n_o)
        else $error("modem requests active in loopback");
    a_req_follow: assert property (!mctl[4] |-> rts_n_o == !mctl[1] && dtr_n_o == !mctl[0])
        else $error("modem requests differ from control");
    a_scratch_echo: assert property (rd && bus_i.addr == 3'h7 |=> rdata_o == scratch)
        else $error("scratch byte lost");
    a_ien_echo: assert property (rd && bus_i.addr == 3'h1 && !dlab |=> rdata_o == ien)
        else $error("interrupt enables read wrong");
    a_irq_masked: assert property (ien[3:0] == 4'h0 |-> !irq_o)
        else $error("interrupt with all sources masked");
    a_low_min16: assert property ($fell(tx_o) |-> !tx_o [*8] ##1 !tx_o [*8])
        else $error("serial low shorter than a bit");
    a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata_o))
        else $error("read data changed without a read");
    c_rx_read: cover property (rd && bus_i.addr == 3'h0);
    c_loop_tx: cover property (mctl[4] && wr && bus_i.addr == 3'h0);
    c_tx_frame: cover property ($fell(tx_o));
endmodule
bind ucc_core ucc_core_asserts chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .rx_i(rx_i), .modem_n_i(modem_n_i), .tx_o(tx_o), .rts_n_o(rts_n_o),
    .dtr_n_o(dtr_n_o), .irq_o(irq_o));
`default_nettype wire

// *** bench/ucc_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucc_remote import ucc_pkg::*; (
    input wire logic clk_i,
    output logic rx_o,
    output ucc_modem_t modem_n_o
);
    // ********
    // far end
    // ********
    // idle at mark
    // status lines held asserted so loopback has something to hide
    initial begin
        rx_o = 1'b1;
        modem_n_o = '0;
    end
    // start, eight bits lsb first, stop; 16 clocks a bit as divisor is 1
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            #1 rx_o = f[i];
            repeat (15) @(posedge clk_i);
        end
        @(posedge clk_i);
        #1 rx_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** bench/uart_channel_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_channel_core_tb import ucc_pkg::*; ;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ucc_bus_t bus_i = '0;
    logic [7:0] rdata_o, v;
    logic rx_i, tx_o, rts_n_o, dtr_n_o, irq_o;
    ucc_modem_t modem_n_i;
    int failures = 0, checks = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    ucc_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .rx_i(rx_i), .modem_n_i(modem_n_i), .tx_o(tx_o), .rts_n_o(rts_n_o),
        .dtr_n_o(dtr_n_o), .irq_o(irq_o));
    ucc_remote far (.clk_i(clk_i), .rx_o(rx_i), .modem_n_o(modem_n_i));
    // ********
    // tasks
    // ********
    function automatic logic [7:0] pat(input int i);
        return {i[3:0], ~i[3:0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle, then one idle edge so read data has landed
    task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 bus_i = '{cs: 1'b1, rd: r, wr: !r, addr: a, wdata: d};
        @(posedge clk_i);
        #1 bus_i = '0;
        @(posedge clk_i);
        #1 v = rdata_o;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00);
        chk(v, e);
    endtask
    // waits for a start edge, then samples each bit at its centre
    task automatic txcap(input logic [7:0] e);
        logic [7:0] b;
        int n = 0;
        while (tx_o !== 1'b0 && n < 3000) begin
            @(posedge clk_i);
            #1 n++;
        end
        repeat (8) @(posedge clk_i);
        #1 chk({7'h0, tx_o}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            #1 b[i] = tx_o;
        end
        chk(b, e);
        repeat (16) @(posedge clk_i);
        #1 chk({7'h0, tx_o}, 8'h01);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    // ********
    // sequence
    // ********
    initial begin
        repeat (4) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        rdc(3'h3, 8'h00);
        rdc(3'h5, 8'h60);
        rdc(3'h2, 8'h01);
        acc(1'b0, 3'h7, 8'ha5);
        rdc(3'h7, 8'ha5);
        acc(1'b0, 3'h3, 8'h80);
        rdc(3'h0, 8'h01);
        acc(1'b0, 3'h3, 8'hbf);
        rdc(3'h0, 8'h00);
        acc(1'b0, 3'h3, 8'h03);
        acc(1'b0, 3'h1, 8'h02);
        rdc(3'h2, 8'h02);
        rdc(3'h2, 8'h01);
        acc(1'b0, 3'h1, 8'h00);
        fork
            txcap(8'h55);
            begin
                acc(1'b0, 3'h0, 8'h55);
                rdc(3'h5, 8'h20);
            end
        join
        repeat (12) @(posedge clk_i);
        rdc(3'h5, 8'h60);
        acc(1'b0, 3'h2, 8'h07);
        fork
            begin
                for (int i = 0; i < 16; i++) acc(1'b0, 3'h0, pat(i));
                rdc(3'h5, 8'h00);
            end
            for (int i = 0; i < 16; i++) txcap(pat(i));
        join
        repeat (12) @(posedge clk_i);
        rdc(3'h5, 8'h60);
        far.send(8'h81, 1'b0);
        far.send(8'h42, 1'b1);
        repeat (20) @(posedge clk_i);
        rdc(3'h5, 8'h69);
        rdc(3'h0, 8'h81);
        rdc(3'h5, 8'h61);
        rdc(3'h0, 8'h42);
        acc(1'b0, 3'h2, 8'h43);
        acc(1'b0, 3'h1, 8'h01);
        for (int i = 0; i < 4; i++) far.send(pat(i), 1'b1);
        repeat (20) @(posedge clk_i);
        rdc(3'h2, 8'hc4);
        for (int i = 0; i < 4; i++) rdc(3'h0, pat(i));
        far.send(8'h24, 1'b1);
        repeat (650) @(posedge clk_i);
        #1 chk({7'h0, irq_o}, 8'h00);
        repeat (110) @(posedge clk_i);
        rdc(3'h2, 8'hcc);
        rdc(3'h0, 8'h24);
        acc(1'b0, 3'h1, 8'h00);
        acc(1'b0, 3'h4, 8'h13);
        chk({6'h0, rts_n_o, dtr_n_o}, 8'h03);
        acc(1'b0, 3'h0, 8'ha7);
        repeat (200) @(posedge clk_i);
        rdc(3'h0, 8'ha7);
        acc(1'b1, 3'h6, 8'h00);
        chk({v[7:4], 4'h0}, 8'h00);
        rdc(3'h4, 8'h13);
        final_report();
    end
endmodule
`default_nettype wire
